// ---- core/fci_pkg.sv ----
package fci_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int FCI_ADDR_W = 17;
	localparam int FCI_CNT_W  = 20;

	// ----------------------------------------
	// timing, printed figure then cycle count
	// ----------------------------------------
	localparam int FCI_CLK_NS     = 10;
	localparam int FCI_T_SETUP_NS = 20;      // address to strobe
	localparam int FCI_T_WE_NS    = 50;      // write strobe low width
	localparam int FCI_T_RD_NS    = 100;     // read access time
	localparam int FCI_T_VPP_NS   = 1000;    // supply settle before writes
	localparam int FCI_T_PROG_NS  = 10000;   // byte program, 10 us
	localparam int FCI_T_ERASE_NS = 9500000; // chip erase, 9.5 ms
	// least times round up
	localparam int FCI_SETUP_CYC =
		(FCI_T_SETUP_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_WE_CYC = (FCI_T_WE_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_RD_CYC = (FCI_T_RD_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_VPP_CYC =
		(FCI_T_VPP_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_PROG_CYC =
		(FCI_T_PROG_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_ERASE_CYC =
		(FCI_T_ERASE_NS + FCI_CLK_NS - 1) / FCI_CLK_NS;
	localparam int FCI_POLL_MAX = 1048575; // read polls before timeout

	// ----------------------------------------
	// command bytes written to the latch, and the erased byte value
	// ----------------------------------------
	localparam logic [7:0] FCI_CMD_READ   = 8'h00;
	localparam logic [7:0] FCI_CMD_PROG   = 8'h40;
	localparam logic [7:0] FCI_CMD_PVER   = 8'hC0;
	localparam logic [7:0] FCI_CMD_APROG  = 8'h10;
	localparam logic [7:0] FCI_CMD_ERASE  = 8'h20;
	localparam logic [7:0] FCI_CMD_EVER   = 8'hA0;
	localparam logic [7:0] FCI_CMD_AERASE = 8'h30;
	localparam logic [7:0] FCI_CMD_RESET  = 8'hFF;
	localparam logic [7:0] FCI_CMD_ID     = 8'h80;
	localparam logic [7:0] FCI_CMD_CID    = 8'h90;
	localparam logic [7:0] FCI_ERASED     = 8'hFF;

	// ----------------------------------------
	// user operations and carriers
	// ----------------------------------------
	typedef enum logic [3:0] {
		FCI_OP_READ   = 4'h0,
		FCI_OP_PROG   = 4'h1,
		FCI_OP_APROG  = 4'h2,
		FCI_OP_ERASE  = 4'h3,
		FCI_OP_EVER   = 4'h4,
		FCI_OP_AERASE = 4'h5,
		FCI_OP_ABORT  = 4'h6,
		FCI_OP_ID     = 4'h7,
		FCI_OP_CID    = 4'h8,
		FCI_OP_RDMODE = 4'h9
	} fci_op_e;

	typedef struct packed {
		fci_op_e                op;
		logic [FCI_ADDR_W-1:0] addr;
		logic [7:0]            data;
	} fci_req_s;

	typedef struct packed {
		logic                  ce_n;
		logic                  oe_n;
		logic                  we_n;
		logic [FCI_ADDR_W-1:0] addr;
		logic [7:0]            dq_o;
		logic                  dq_oe;
	} fci_bus_s;

endpackage

// ---- core/fci_bus_cycle.sv ----
`timescale 1ns/1ps
module fci_bus_cycle
	import fci_pkg::*;
(
	input  wire logic                  sys_clk, // system clock
	input  wire logic                  rst,     // sync reset
	input  wire logic                  start,   // begin one bus cycle
	input  wire logic                  wr,      // 1 write, 0 read
	input  wire logic [FCI_ADDR_W-1:0] addr,    // cycle address
	input  wire logic [7:0]            wdata,   // write byte
	input  wire logic [7:0]            dq_i,    // data lines in
	output fci_bus_s                   bus,     // pins to the flash
	output logic [7:0]                 rdata,   // byte read
	output logic                       done     // cycle finished pulse
);

	typedef enum logic [1:0] {
		FCI_B_IDLE   = 2'b00,
		FCI_B_SETUP  = 2'b01,
		FCI_B_STROBE = 2'b10,
		FCI_B_HOLD   = 2'b11
	} fci_bst_e;

	localparam fci_bus_s FCI_BUS_IDLE = '{1'b1, 1'b1, 1'b1, '0, '0, 1'b0};

	fci_bst_e       st_r, st_nxt;
	fci_bus_s       bus_r, bus_nxt;
	logic [7:0]     rdata_r, rdata_nxt;
	logic           done_r, done_nxt;
	logic [3:0]     cnt_r, cnt_nxt;

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	// address and data held over the whole cycle, so both latch edges
	// of the write strobe see stable values
	always_comb begin
		st_nxt    = st_r;
		bus_nxt   = bus_r;
		rdata_nxt = rdata_r;
		done_nxt  = 1'b0;
		cnt_nxt   = cnt_r;
		unique case (st_r)
			FCI_B_IDLE: begin
				if (start) begin
					bus_nxt.ce_n  = 1'b0;
					bus_nxt.addr  = addr;
					bus_nxt.dq_o  = wdata;
					bus_nxt.dq_oe = wr;
					cnt_nxt       = 4'(FCI_SETUP_CYC - 1);
					st_nxt        = FCI_B_SETUP;
				end
			end
			FCI_B_SETUP: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0) begin
					// never strobe write with output enable low
					bus_nxt.we_n = ~bus_r.dq_oe;
					bus_nxt.oe_n = bus_r.dq_oe;
					cnt_nxt = bus_r.dq_oe ? 4'(FCI_WE_CYC - 1)
					                      : 4'(FCI_RD_CYC - 1);
					st_nxt  = FCI_B_STROBE;
				end
			end
			FCI_B_STROBE: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0) begin
					if (!bus_r.dq_oe)
						rdata_nxt = dq_i;
					bus_nxt.we_n = 1'b1;
					bus_nxt.oe_n = 1'b1;
					st_nxt       = FCI_B_HOLD;
				end
			end
			FCI_B_HOLD: begin
				// data dropped one edge after the strobe rises; the address
				// stays put so a polled byte never sees its address move
				bus_nxt      = FCI_BUS_IDLE;
				bus_nxt.addr = bus_r.addr;
				done_nxt = 1'b1;
				st_nxt   = FCI_B_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r    <= FCI_B_IDLE;
			bus_r   <= FCI_BUS_IDLE;
			rdata_r <= 8'h00;
			done_r  <= 1'b0;
			cnt_r   <= 4'h0;
		end else begin
			st_r    <= st_nxt;
			bus_r   <= bus_nxt;
			rdata_r <= rdata_nxt;
			done_r  <= done_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign bus   = bus_r;
	assign rdata = rdata_r;
	assign done  = done_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_we_needs_oe: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_r.we_n |-> (!bus_r.ce_n && bus_r.oe_n))
		else $error("write strobe without chip enable or with oe low");
	a_addr_held: assert property (@(posedge sys_clk) disable iff (rst)
		(!bus_r.ce_n && !$past(bus_r.ce_n)) |-> $stable(bus_r.addr))
		else $error("address moved inside a bus cycle");
	a_data_at_rise: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(bus_r.we_n) |-> (bus_r.dq_oe && $stable(bus_r.dq_o)))
		else $error("write data not held across strobe rise");
	a_no_drive_rd: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_r.oe_n |-> !bus_r.dq_oe)
		else $error("host drives data while flash output enabled");
	a_we_width: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(bus_r.we_n) |-> !bus_r.we_n [*5] ##1 bus_r.we_n)
		else $error("write strobe width wrong");

endmodule

// ---- core/fci_host.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - write needs strobe low, chip enable low, oe high, supply high.
// - address taken at strobe fall, data at strobe rise; hold both.
// - program: 40H then address and data; 10 us internal timer.
// - after program write C0H then read back verify data.
// - host keeps address fixed while polling auto program.
// - chip erase is 20H twice; 9.5 ms internal timer.
// - erase verify writes A0H with address, then reads it.
// - two FFH writes abort program or erase, back to read mode.
module fci_host
	import fci_pkg::*;
#(
	parameter int ERASE_CYC = FCI_ERASE_CYC, // chip erase wait
	parameter int POLL_MAX  = FCI_POLL_MAX   // polls before timeout
) (
	input  wire logic        sys_clk,   // 100 MHz clock
	input  wire logic        rst,       // sync reset, active high
	input  wire logic        req_valid, // request offered
	input  fci_req_s         req,       // operation, address, data
	output logic             req_ready, // request taken when valid
	output logic             rsp_valid, // operation finished pulse
	output logic [7:0]       rsp_data,  // byte read or polled
	output logic             rsp_err,   // timeout or erase not armed
	output logic             vpp_hi,    // select high program supply
	output fci_bus_s         bus,       // flash pins
	input  wire logic [7:0]  dq_i       // flash data lines in
);

	typedef enum logic [3:0] {
		FCI_S_IDLE = 4'h0,
		FCI_S_VPP  = 4'h1,
		FCI_S_W1   = 4'h2,
		FCI_S_W2   = 4'h3,
		FCI_S_WAIT = 4'h4,
		FCI_S_VER  = 4'h5,
		FCI_S_RD   = 4'h6,
		FCI_S_POLL = 4'h7,
		FCI_S_DONE = 4'h8
	} fci_st_e;

	fci_st_e               st_r, st_nxt;
	fci_req_s              req_r, req_nxt;
	logic [FCI_CNT_W-1:0]  cnt_r, cnt_nxt;
	logic                  ready_r, ready_nxt;
	logic                  rvld_r, rvld_nxt;
	logic [7:0]            rdat_r, rdat_nxt;
	logic                  err_r, err_nxt;
	logic                  vpp_r, vpp_nxt;
	logic                  armed_r, armed_nxt;
	logic                  go_r, go_nxt;
	logic                  wr_r, wr_nxt;
	logic [7:0]            wd_r, wd_nxt;
	logic [7:0]            bus_rd;
	logic                  bus_done;

	// ----------------------------------------
	// per operation decode
	// ----------------------------------------
	logic [7:0] c1;
	logic       has_w2;
	logic [7:0] w2_data;
	logic       fin_rd;
	logic       polls;
	logic       is_erase;

	always_comb begin
		c1       = FCI_CMD_READ;
		has_w2   = 1'b0;
		w2_data  = req_r.data;
		fin_rd   = 1'b0;
		polls    = 1'b0;
		is_erase = 1'b0;
		unique case (req_r.op)
			FCI_OP_PROG: begin
				c1 = FCI_CMD_PROG;
				has_w2 = 1'b1;
			end
			FCI_OP_APROG: begin
				c1 = FCI_CMD_APROG;
				has_w2 = 1'b1;
				polls = 1'b1;
			end
			FCI_OP_ERASE: begin
				c1 = FCI_CMD_ERASE;
				has_w2 = 1'b1;
				w2_data = FCI_CMD_ERASE;
				is_erase = 1'b1;
			end
			FCI_OP_EVER: begin
				c1 = FCI_CMD_EVER;
				fin_rd = 1'b1;
			end
			FCI_OP_AERASE: begin
				c1 = FCI_CMD_AERASE;
				has_w2 = 1'b1;
				w2_data = FCI_CMD_AERASE;
				polls = 1'b1;
				is_erase = 1'b1;
			end
			FCI_OP_ABORT: begin
				c1 = FCI_CMD_RESET;
				has_w2 = 1'b1;
				w2_data = FCI_CMD_RESET;
			end
			FCI_OP_ID: begin
				c1 = FCI_CMD_ID;
				fin_rd = 1'b1;
			end
			FCI_OP_CID: begin
				c1 = FCI_CMD_CID;
				fin_rd = 1'b1;
			end
			default: begin
				c1 = FCI_CMD_READ;
			end
		endcase
	end

	// poll finished: true byte back, or top bit set for erase
	logic poll_hit;
	assign poll_hit = (req_r.op == FCI_OP_APROG) ?
		(bus_rd == req_r.data) : bus_rd[7];

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	// one bus cycle at a time; nothing is written while the flash is
	// timing an operation, so no write can land inside one
	always_comb begin
		st_nxt    = st_r;
		req_nxt   = req_r;
		cnt_nxt   = cnt_r;
		ready_nxt = ready_r;
		rvld_nxt  = 1'b0;
		rdat_nxt  = rdat_r;
		err_nxt   = err_r;
		vpp_nxt   = vpp_r;
		armed_nxt = armed_r;
		go_nxt    = 1'b0;
		wr_nxt    = wr_r;
		wd_nxt    = wd_r;
		unique case (st_r)
			FCI_S_IDLE: begin
				if (req_valid && ready_r) begin
					req_nxt   = req;
					ready_nxt = 1'b0;
					err_nxt   = 1'b0;
					if (req.op == FCI_OP_READ) begin
						go_nxt = 1'b1;
						wr_nxt = 1'b0;
						st_nxt = FCI_S_RD;
					end else begin
						vpp_nxt = 1'b1;
						cnt_nxt = FCI_CNT_W'(FCI_VPP_CYC - 1);
						st_nxt  = FCI_S_VPP;
					end
				end
			end
			FCI_S_VPP: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == '0) begin
					go_nxt = 1'b1;
					wr_nxt = 1'b1;
					wd_nxt = c1;
					st_nxt = FCI_S_W1;
				end
			end
			FCI_S_W1: begin
				if (bus_done) begin
					go_nxt = has_w2 | fin_rd;
					wr_nxt = has_w2;
					wd_nxt = w2_data;
					st_nxt = has_w2 ? FCI_S_W2 :
					         fin_rd ? FCI_S_RD : FCI_S_DONE;
				end
			end
			FCI_S_W2: begin
				if (bus_done) begin
					if (req_r.op == FCI_OP_PROG) begin
						armed_nxt = 1'b1;
						cnt_nxt = FCI_CNT_W'(FCI_PROG_CYC - 1);
						st_nxt  = FCI_S_WAIT;
					end else if (req_r.op == FCI_OP_ERASE) begin
						err_nxt = ~armed_r;
						cnt_nxt = FCI_CNT_W'(ERASE_CYC - 1);
						st_nxt  = FCI_S_WAIT;
					end else if (polls) begin
						if (req_r.op == FCI_OP_APROG)
							armed_nxt = 1'b1;
						else
							err_nxt = ~armed_r;
						go_nxt  = 1'b1;
						wr_nxt  = 1'b0;
						cnt_nxt = '0;
						st_nxt  = FCI_S_POLL;
					end else begin
						st_nxt = FCI_S_DONE;
					end
				end
			end
			FCI_S_WAIT: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == '0) begin
					go_nxt = ~is_erase;
					wr_nxt = 1'b1;
					wd_nxt = FCI_CMD_PVER;
					st_nxt = is_erase ? FCI_S_DONE : FCI_S_VER;
				end
			end
			FCI_S_VER: begin
				if (bus_done) begin
					go_nxt = 1'b1;
					wr_nxt = 1'b0;
					st_nxt = FCI_S_RD;
				end
			end
			FCI_S_RD: begin
				if (bus_done) begin
					rdat_nxt = bus_rd;
					if (req_r.op == FCI_OP_EVER && bus_rd != FCI_ERASED)
						armed_nxt = 1'b1;
					st_nxt = FCI_S_DONE;
				end
			end
			FCI_S_POLL: begin
				// address stays on the requested byte, under auto program or auto erase
				if (bus_done) begin
					rdat_nxt = bus_rd;
					cnt_nxt  = cnt_r + 1'b1;
					if (poll_hit) begin
						st_nxt = FCI_S_DONE;
					end else if (cnt_r == FCI_CNT_W'(POLL_MAX)) begin
						err_nxt = 1'b1;
						st_nxt  = FCI_S_DONE;
					end else begin
						go_nxt = 1'b1;
						wr_nxt = 1'b0;
					end
				end
			end
			FCI_S_DONE: begin
				// dropping the supply returns the latch to read
				vpp_nxt   = 1'b0;
				rvld_nxt  = 1'b1;
				ready_nxt = 1'b1;
				st_nxt    = FCI_S_IDLE;
			end
			default: begin
				st_nxt = FCI_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r    <= FCI_S_IDLE;
			req_r   <= '{FCI_OP_READ, '0, 8'h00};
			cnt_r   <= '0;
			ready_r <= 1'b1;
			rvld_r  <= 1'b0;
			rdat_r  <= 8'h00;
			err_r   <= 1'b0;
			vpp_r   <= 1'b0;
			armed_r <= 1'b0;
			go_r    <= 1'b0;
			wr_r    <= 1'b0;
			wd_r    <= 8'h00;
		end else begin
			st_r    <= st_nxt;
			req_r   <= req_nxt;
			cnt_r   <= cnt_nxt;
			ready_r <= ready_nxt;
			rvld_r  <= rvld_nxt;
			rdat_r  <= rdat_nxt;
			err_r   <= err_nxt;
			vpp_r   <= vpp_nxt;
			armed_r <= armed_nxt;
			go_r    <= go_nxt;
			wr_r    <= wr_nxt;
			wd_r    <= wd_nxt;
		end
	end

	// ----------------------------------------
	// pin cycle engine
	// ----------------------------------------
	fci_bus_cycle u_cyc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (go_r),
		.wr      (wr_r),
		.addr    (req_r.addr),
		.wdata   (wd_r),
		.dq_i    (dq_i),
		.bus     (bus),
		.rdata   (bus_rd),
		.done    (bus_done)
	);

	assign req_ready = ready_r;
	assign rsp_valid = rvld_r;
	assign rsp_data  = rdat_r;
	assign rsp_err   = err_r;
	assign vpp_hi    = vpp_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_vpp_hi: assert property (@(posedge sys_clk) disable iff (rst)
		!bus.we_n |-> vpp_r)
		else $error("write strobe without high supply");
	a_wait_no_wr: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == FCI_S_WAIT) |-> (bus.we_n && bus.ce_n))
		else $error("bus used during timed operation");
	a_prog_time: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == FCI_S_W2 && bus_done && req_r.op == FCI_OP_PROG)
		|=> (st_r == FCI_S_WAIT && cnt_r == FCI_CNT_W'(FCI_PROG_CYC - 1)))
		else $error("program wait not loaded with 10 us");
	a_verify_cmd: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == FCI_S_VER && $rose(bus.we_n)) |-> bus.dq_o == FCI_CMD_PVER)
		else $error("verify command byte wrong");
	a_poll_addr: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == FCI_S_POLL) |-> bus.addr == req_r.addr)
		else $error("poll address moved");
	a_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		rsp_valid |-> (req_ready && !vpp_hi) ##1 !rsp_valid)
		else $error("response not a single pulse");

endmodule

// ---- dv/fci_flash_model.sv ----
`timescale 1ns/1ps
module fci_flash_model
	import fci_pkg::*;
#(
	parameter logic [7:0] MFR_ID    = 8'h5E, // arbitrary value
	parameter logic [7:0] DEV_ID    = 8'h6B, // arbitrary value
	parameter logic [7:0] CDEV_ID   = 8'h7C, // arbitrary value
	parameter int         PROG_NS   = 10000, // byte program time
	parameter int         ERASE_NS  = 400,   // shortened chip erase
	parameter int         APROG_NS  = 1000,  // auto program time
	parameter int         AERASE_NS = 1500   // auto erase time
) (
	input  fci_bus_s         bus,    // host pins
	input  wire logic        vpp_hi, // high supply applied
	output logic [7:0]       q,      // data lines from flash
	output logic             q_en,   // flash drives data lines
	output logic             viol    // host broke a bus rule
);
	localparam logic [7:0] AP2 = 8'h50;
	logic [7:0]            mem [0:(1<<FCI_ADDR_W)-1];
	logic [7:0]            cmd, pend, last, wd, pdat, qv;
	logic [FCI_ADDR_W-1:0] wa, pa, ea;
	logic                  busy, armed, wok;
	int                    tns;
	event                  go;

	// ----------------------------------------
	// power-up state, memory blank
	// ----------------------------------------
	initial begin
		for (int i = 0; i < (1<<FCI_ADDR_W); i++) mem[i] = FCI_ERASED;
		{cmd, pend, last} = '0;
		{busy, armed, wok, viol} = '0;
	end

	// latch forced to read on any supply change
	always @(vpp_hi) begin
		cmd = FCI_CMD_READ;
		pend = 8'h00;
	end

	// internal timer; writes are locked out meanwhile
	task start_busy(input int ns);
		busy = 1'b1;
		tns = ns;
		-> go;
	endtask
	always @(go) begin
		#(tns);
		busy = 1'b0;
	end

	task exec(input logic [FCI_ADDR_W-1:0] a, input logic [7:0] d);
		if (pend == FCI_CMD_RESET) begin
			pend = 8'h00;
			if (d == FCI_CMD_RESET) cmd = FCI_CMD_READ;
		end else if (pend != 8'h00 && d == FCI_CMD_RESET) begin
			pend = FCI_CMD_RESET;
		end else if (pend == FCI_CMD_PROG) begin
			pend = 8'h00;
			mem[a] = mem[a] & d;
			pa = a;
			armed = 1'b1;
			start_busy(PROG_NS);
		end else if (pend == FCI_CMD_APROG || pend == AP2) begin
			pend = 8'h00;
			mem[a] = mem[a] & d;
			{pa, pdat, armed, cmd} = {a, d, 1'b1, FCI_CMD_APROG};
			start_busy(APROG_NS);
		end else if (pend != 8'h00) begin
			// erase only when armed and the code repeats
			if (armed && d == pend) begin
				for (int i = 0; i < (1<<FCI_ADDR_W); i++) mem[i] = FCI_ERASED;
				cmd = (d == FCI_CMD_AERASE) ? d : FCI_CMD_READ;
				start_busy((d == FCI_CMD_AERASE) ? AERASE_NS : ERASE_NS);
			end
			pend = 8'h00;
		end else begin
			case (d)
				FCI_CMD_READ, FCI_CMD_PVER: cmd = d;
				FCI_CMD_ID, FCI_CMD_CID: cmd = d;
				FCI_CMD_EVER: {cmd, ea} = {d, a};
				FCI_CMD_PROG, FCI_CMD_APROG, AP2: pend = d;
				FCI_CMD_ERASE, FCI_CMD_AERASE, FCI_CMD_RESET: pend = d;
				default: ;
			endcase
		end
	endtask

	// ----------------------------------------
	// write cycles
	// ----------------------------------------
	always @(negedge bus.we_n) begin
		wok = !bus.ce_n && bus.oe_n && vpp_hi && !busy;
		if (bus.oe_n !== 1'b1) viol = 1'b1;
		wa = bus.addr;
		wd = bus.dq_o;
	end
	always @(posedge bus.we_n) begin
		// hold across the strobe is checked, not assumed
		if (wok && (wd !== bus.dq_o || wa !== bus.addr)) viol = 1'b1;
		if (wok) exec(wa, bus.dq_o);
		wok = 1'b0;
	end
	always @(bus.addr) begin
		if (busy && cmd == FCI_CMD_APROG && bus.addr !== pa) viol = 1'b1;
	end
	always @(negedge bus.oe_n) begin
		if (cmd == FCI_CMD_EVER && !bus.ce_n && mem[ea] != FCI_ERASED)
			armed = 1'b1;
	end

	// read path; released lines show the inverse of the last byte
	always @* begin
		q_en = !bus.ce_n && !bus.oe_n && bus.we_n;
		if (busy && cmd == FCI_CMD_APROG) qv = ~pdat;
		else if (busy && cmd == FCI_CMD_AERASE) qv = 8'h00;
		else if (busy) qv = ~mem[bus.addr];
		else case (cmd)
			FCI_CMD_PVER: qv = mem[pa];
			FCI_CMD_EVER: qv = mem[ea];
			FCI_CMD_ID, FCI_CMD_CID: qv = (bus.addr == '0) ? MFR_ID :
				(bus.addr == 1) ? ((cmd == FCI_CMD_ID) ? DEV_ID : CDEV_ID) : 8'h00;
			default: qv = mem[bus.addr];
		endcase
		q = q_en ? qv : ~last;
	end
	always @(negedge q_en) last = qv;
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb
	import fci_pkg::*;
;
	localparam logic [7:0] MFR_ID  = 8'h5E; // arbitrary value
	localparam logic [7:0] DEV_ID  = 8'h6B; // arbitrary value
	localparam logic [7:0] CDEV_ID = 8'h7C; // arbitrary value
	logic       sys_clk, rst, req_valid, req_ready, rsp_valid, rsp_err;
	logic       vpp_hi, fl_en, viol;
	logic [7:0] rsp_data, dq_i, fl_q;
	fci_req_s   req;
	fci_bus_s   bus;
	int         errors, samples_checked;

	// host drive wins only when enabled; otherwise the flash q lines, which never float
	assign dq_i = bus.dq_oe ? bus.dq_o : fl_q;

	fci_host #(.ERASE_CYC(50), .POLL_MAX(20)) i_fci_host (
		.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_err(rsp_err), .vpp_hi(vpp_hi), .bus(bus), .dq_i(dq_i));
	fci_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID), .CDEV_ID(CDEV_ID))
	i_fci_flash_model (.bus(bus), .vpp_hi(vpp_hi), .q(fl_q), .q_en(fl_en),
		.viol(viol));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task final_report;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// one request, held until taken, then wait for the answer
	task do_op(input fci_op_e op, input logic [16:0] a, input logic [7:0] d);
		int n;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = '{op: op, addr: a, data: d};
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
	endtask

	// bus watch: no clash, writes only under high supply
	always @(negedge sys_clk) begin
		if (!rst && bus.dq_oe === 1'b1 && fl_en === 1'b1)
			chk("data line clash", 8'h00, 8'h01);
		if (!rst && bus.we_n === 1'b0 && vpp_hi !== 1'b1)
			chk("supply at write", 8'h01, {7'h00, vpp_hi});
	end

	task t_reset;
		chk("idle pins", 8'h1C, {3'b000, bus.ce_n, bus.oe_n, bus.we_n,
			bus.dq_oe, vpp_hi});
		chk("ready", 8'h01, {7'h00, req_ready});
		$display("test reset finished");
	endtask

	task t_read_unarmed;
		i_fci_flash_model.mem[5] = 8'h3C;
		do_op(FCI_OP_READ, 17'h00005, 8'h00);
		chk("read byte", 8'h3C, rsp_data);
		do_op(FCI_OP_ERASE, 17'h00000, 8'h00);
		chk("erase refused", 8'h01, {7'h00, rsp_err});
		do_op(FCI_OP_AERASE, 17'h00000, 8'h00);
		chk("auto erase refused", 8'h01, {7'h00, rsp_err});
		do_op(FCI_OP_READ, 17'h00005, 8'h00);
		chk("kept byte", 8'h3C, rsp_data);
		$display("test read_unarmed finished");
	endtask

	task t_program;
		do_op(FCI_OP_PROG, 17'h12345, 8'h5A);
		chk("verify byte", 8'h5A, rsp_data);
		chk("prog err", 8'h00, {7'h00, rsp_err});
		do_op(FCI_OP_APROG, 17'h00100, 8'hA5);
		chk("auto prog byte", 8'hA5, rsp_data);
		chk("auto prog err", 8'h00, {7'h00, rsp_err});
		do_op(FCI_OP_READ, 17'h12345, 8'h00);
		chk("programmed", 8'h5A, rsp_data);
		$display("test program finished");
	endtask

	task t_verify_id;
		do_op(FCI_OP_EVER, 17'h12345, 8'h00);
		chk("ever used", 8'h5A, rsp_data);
		do_op(FCI_OP_EVER, 17'h00007, 8'h00);
		chk("ever blank", FCI_ERASED, rsp_data);
		for (int k = 0; k < 4; k++) begin
			do_op((k < 2) ? FCI_OP_ID : FCI_OP_CID, 17'(k % 2), 8'h00);
			chk("id code", (k % 2 == 0) ? MFR_ID : (k == 1) ? DEV_ID :
				CDEV_ID, rsp_data);
		end
		$display("test verify_id finished");
	endtask

	task t_abort;
		i_fci_flash_model.mem[9] = 8'h66;
		do_op(FCI_OP_ABORT, 17'h00009, 8'h00);
		do_op(FCI_OP_READ, 17'h00009, 8'h00);
		chk("after abort", 8'h66, rsp_data);
		do_op(FCI_OP_RDMODE, 17'h00009, 8'h00);
		do_op(FCI_OP_READ, 17'h00009, 8'h00);
		chk("read mode", 8'h66, rsp_data);
		$display("test abort finished");
	endtask

	task t_erase;
		do_op(FCI_OP_ERASE, 17'h00000, 8'h00);
		chk("erase err", 8'h00, {7'h00, rsp_err});
		do_op(FCI_OP_READ, 17'h12345, 8'h00);
		chk("erased", FCI_ERASED, rsp_data);
		i_fci_flash_model.mem[5] = 8'h00;
		do_op(FCI_OP_AERASE, 17'h00005, 8'h00);
		chk("auto erase poll", FCI_ERASED, rsp_data);
		chk("auto erase err", 8'h00, {7'h00, rsp_err});
		do_op(FCI_OP_READ, 17'h00005, 8'h00);
		chk("auto erased", FCI_ERASED, rsp_data);
		chk("bus rules", 8'h00, {7'h00, viol});
		$display("test erase finished");
	endtask

	// watchdog, far beyond the expected run of some 35 us
	initial begin
		#500000;
		chk("watchdog", 8'h00, 8'h01);
		final_report;
	end

	initial begin
		errors = 0;
		samples_checked = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		repeat (6) @(negedge sys_clk);
		t_reset;
		rst = 1'b0;
		t_read_unarmed;
		t_program;
		t_verify_id;
		t_abort;
		t_erase;
		final_report;
	end
endmodule
